// *** abz_pkg.sv ***
// Constants, register layout and timing for the ABZ and PWM angle output block
// Operation
// - A and B form a quadrature pair, B lagging A by a quarter period.
// - Channel A gives exactly N pulses per turn, N from 1 to 256.
// - The 8-bit pulses-per-turn code is split over registers 0x4 and 0x5.
// - After reset the code selects 256 pulses per channel per turn.
// - The code holds N minus one: 0 gives 4 edges, 255 gives 1024.
// - Index Z asserts once per turn, starting 3 to 6 quarter steps past zero angle; stuck high for N = 1 at full width.
// - A 4-bit index shape field split over registers 0x4 and 0x5 sets Z place and width.
// - Shape 0000: Z rises with B falling and lasts half an A pulse.
// - Hysteresis above angle noise stops spurious ABZ toggling near transitions.
// - ABZ state recomputed just under 16 MHz; edges never closer than one update.
// - PWM duty follows the angle, bounded between 1/130 and 129/130.
// - PWM duty steps with 12-bit angular resolution.
// - On fraction is (1 + 128 * angle fraction) / 130.
package abz_pkg;

  // ****************************************
  // Widths and register map
  // ****************************************
  localparam int          ANG_W          = 12;
  localparam int          POS_W          = 11;
  localparam int          ADDR_W         = 5;
  localparam logic [4:0]  ADDR_CFG_LOW   = 5'h04;
  localparam logic [4:0]  ADDR_CFG_HIGH  = 5'h05;
  localparam logic [7:0]  RST_CFG_LOW    = 8'hc0;
  localparam logic [7:0]  RST_CFG_HIGH   = 8'h3f;

  // Field positions
  localparam int          PPT_LO_MSB     = 7;
  localparam int          PPT_LO_LSB     = 6;
  localparam int          PPT_HI_MSB     = 5;
  localparam int          PPT_HI_LSB     = 0;
  localparam int          ISC_HI_MSB     = 7;
  localparam int          ISC_HI_LSB     = 6;
  localparam int          ISC_LO_MSB     = 5;
  localparam int          ISC_LO_LSB     = 4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_PERIOD_PS  = 5000;
  localparam int          UPDATE_PERIOD_PS = 62500;
  localparam int          UPDATE_CYC     = (UPDATE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0]  UPDATE_LAST    = 4'(UPDATE_CYC - 1);

  // ****************************************
  // Hysteresis and index shape
  // ****************************************
  localparam logic [11:0] HYST_LSB       = 12'h002;
  localparam logic [11:0] HYST_NEG       = 12'(~HYST_LSB + 12'h001);
  localparam logic [10:0] Z_START_BASE   = 11'h003;
  localparam logic [10:0] Z_LEN_HALF     = 11'h002;
  localparam logic [10:0] Z_LEN_QUARTER  = 11'h001;
  localparam logic [10:0] Z_LEN_3Q       = 11'h003;
  localparam logic [10:0] Z_LEN_FULL     = 11'h004;

  // ****************************************
  // PWM: 130 units of 32 clocks each
  // ****************************************
  localparam int          PWM_UNITS      = 130;
  localparam int          PWM_UNIT_CYC   = 32;
  localparam logic [12:0] PWM_PERIOD     = 13'(PWM_UNITS * PWM_UNIT_CYC);
  localparam logic [12:0] PWM_MIN_ON     = 13'(PWM_UNIT_CYC);
  localparam logic [12:0] PWM_MAX_ON     = 13'((PWM_UNITS - 1) * PWM_UNIT_CYC);

endpackage

// *** abz_pwm_gen.sv ***
// PWM generator whose on-time encodes the 12-bit angle
`timescale 1ns/1ps
module abz_pwm_gen
  import abz_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [ANG_W-1:0]  angle,
  output      logic              pwm_out
);

  logic [12:0] cnt_q;
  logic [12:0] on_q;
  logic        pwm_q;

  // ****************************************
  // Period counter and on-time latch
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 13'h0000;
    end else if (cnt_q == PWM_PERIOD - 13'h0001) begin
      cnt_q <= 13'h0000;
    end else begin
      cnt_q <= cnt_q + 13'h0001;
    end
  end

  // Latched once per period so the duty never changes mid-pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      on_q <= PWM_MIN_ON;
    end else if (cnt_q == PWM_PERIOD - 13'h0001) begin
      on_q <= PWM_MIN_ON + {1'b0, angle};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= (cnt_q < on_q);
    end
  end

  assign pwm_out = pwm_q;

  // ****************************************
  // Checks
  // ****************************************
  logic [12:0] hi_cnt_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hi_cnt_q <= 13'h0000;
    end else if (pwm_q) begin
      hi_cnt_q <= hi_cnt_q + 13'h0001;
    end else begin
      hi_cnt_q <= 13'h0000;
    end
  end

  a_pwm_on_exact: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(pwm_q) |-> hi_cnt_q == on_q)
    else $error("PWM high time differs from latched on-time");

  a_pwm_on_bounds: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(pwm_q) |-> (hi_cnt_q >= PWM_MIN_ON) && (hi_cnt_q <= PWM_MAX_ON))
    else $error("PWM high time outside 1/130 to 129/130");

  a_pwm_period_start: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(pwm_q) |-> $past(cnt_q) == 13'h0000)
    else $error("PWM pulse did not start at period start");

endmodule

// *** abz_pwm_angle_output.sv ***
// Angle to ABZ quadrature and PWM output converter with its configuration registers
`timescale 1ns/1ps
module abz_pwm_angle_output
  import abz_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [ANG_W-1:0]  angle,
  input  wire logic              cfg_wr_en,
  input  wire logic [ADDR_W-1:0] cfg_addr,
  input  wire logic [7:0]        cfg_wdata,
  output      logic [7:0]        cfg_rdata,
  output      logic              enc_a,
  output      logic              enc_b,
  output      logic              enc_z,
  output      logic              pwm_out
);

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] abz_config_low_q;
  logic [7:0] abz_config_high_q;
  logic [7:0] cfg_rdata_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      abz_config_low_q <= RST_CFG_LOW;
    end else if (cfg_wr_en && (cfg_addr == ADDR_CFG_LOW)) begin
      abz_config_low_q <= cfg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      abz_config_high_q <= RST_CFG_HIGH;
    end else if (cfg_wr_en && (cfg_addr == ADDR_CFG_HIGH)) begin
      abz_config_high_q <= cfg_wdata;
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_rdata_q <= 8'h00;
    end else begin
      case (cfg_addr)
        ADDR_CFG_LOW:  cfg_rdata_q <= abz_config_low_q;
        ADDR_CFG_HIGH: cfg_rdata_q <= abz_config_high_q;
        default:       cfg_rdata_q <= 8'h00;
      endcase
    end
  end

  assign cfg_rdata = cfg_rdata_q;

  // ****************************************
  // Field decode
  // ****************************************
  logic [7:0]  pulses_per_turn_code;
  logic [3:0]  index_shape_code;
  logic [10:0] edges_per_turn;
  logic [10:0] half_turn;

  assign pulses_per_turn_code = {abz_config_high_q[PPT_HI_MSB:PPT_HI_LSB],
                                 abz_config_low_q[PPT_LO_MSB:PPT_LO_LSB]};
  assign index_shape_code     = {abz_config_high_q[ISC_HI_MSB:ISC_HI_LSB],
                                 abz_config_low_q[ISC_LO_MSB:ISC_LO_LSB]};
  // Code is N-1, four edges per pulse
  assign edges_per_turn = {1'b0, pulses_per_turn_code, 2'b00} + 11'h004;
  assign half_turn      = {1'b0, edges_per_turn[10:1]};

  // ****************************************
  // Update tick
  // ****************************************
  logic [3:0] tick_cnt_q;
  logic       tick;
  logic       upd_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 4'h0;
    end else if (tick_cnt_q == UPDATE_LAST) begin
      tick_cnt_q <= 4'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 4'h1;
    end
  end

  // 62.5 ns rounded up to 13 clocks, so the rate stays just under 16 MHz
  assign tick = (tick_cnt_q == UPDATE_LAST);

  // Outputs refresh one clock after a step, so config writes cannot glitch Z off the grid
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= tick;
    end
  end

  // ****************************************
  // Hysteresis on the angle
  // ****************************************
  // Costs a little position accuracy but keeps noise from dithering an edge
  logic [11:0] ang_h_q;
  logic [11:0] ang_diff;
  logic        ang_away;

  assign ang_diff = angle - ang_h_q;
  assign ang_away = (ang_diff > HYST_LSB) && (ang_diff < HYST_NEG);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ang_h_q <= 12'h000;
    end else if (ang_away) begin
      ang_h_q <= angle;
    end
  end

  // ****************************************
  // Quadrature position stepping
  // ****************************************
  logic [22:0] ang_prod;
  logic [10:0] target;
  logic [10:0] pos_q;
  logic [10:0] pos_d;
  logic [10:0] step_raw;
  logic [10:0] step_dist;

  assign ang_prod  = {11'h000, ang_h_q} * {12'h000, edges_per_turn};
  assign target    = ang_prod[22:12];
  assign step_raw  = target - pos_q;
  assign step_dist = step_raw[10] ? (step_raw + edges_per_turn) : step_raw;

  always_comb begin
    pos_d = pos_q;
    if (tick) begin
      if (pos_q >= edges_per_turn) begin
        pos_d = target;
      end else if (step_dist == 11'h000) begin
        pos_d = pos_q;
      end else if (step_dist < half_turn) begin
        pos_d = (pos_q == edges_per_turn - 11'h001) ? 11'h000 : pos_q + 11'h001;
      end else begin
        pos_d = (pos_q == 11'h000) ? edges_per_turn - 11'h001 : pos_q - 11'h001;
      end
    end
  end

  // One quarter step per update keeps edges an update apart
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pos_q <= 11'h000;
    end else begin
      pos_q <= pos_d;
    end
  end

  // ****************************************
  // Index window
  // ****************************************
  logic [10:0] z_start;
  logic [11:0] z_off0;
  logic [11:0] z_off1;
  logic [11:0] z_off2;
  logic [10:0] z_len;
  logic        z_d;

  assign z_start = Z_START_BASE + {9'h000, index_shape_code[1:0]};
  // Two turns added so the offset never goes negative, even for N = 1
  assign z_off0  = {1'b0, pos_q} + {edges_per_turn, 1'b0} - {1'b0, z_start};
  assign z_off1  = (z_off0 >= {1'b0, edges_per_turn}) ? z_off0 - {1'b0, edges_per_turn} : z_off0;
  assign z_off2  = (z_off1 >= {1'b0, edges_per_turn}) ? z_off1 - {1'b0, edges_per_turn} : z_off1;

  always_comb begin
    case (index_shape_code[3:2])
      2'h0:    z_len = Z_LEN_HALF;
      2'h1:    z_len = Z_LEN_QUARTER;
      2'h2:    z_len = Z_LEN_3Q;
      2'h3:    z_len = Z_LEN_FULL;
      default: z_len = Z_LEN_HALF;
    endcase
  end

  assign z_d = (z_off2 < {1'b0, z_len});

  // ****************************************
  // Output registers
  // ****************************************
  logic enc_a_q;
  logic enc_b_q;
  logic enc_z_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enc_a_q <= 1'b0;
      enc_b_q <= 1'b0;
    end else begin
      enc_a_q <= ~pos_q[1];
      enc_b_q <= pos_q[1] ^ pos_q[0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enc_z_q <= 1'b0;
    end else if (upd_q) begin
      enc_z_q <= z_d;
    end
  end

  assign enc_a = enc_a_q;
  assign enc_b = enc_b_q;
  assign enc_z = enc_z_q;

  abz_pwm_gen u_pwm (
    .ref_clk (ref_clk),
    .rst     (rst),
    .angle   (angle),
    .pwm_out (pwm_out)
  );

  // ****************************************
  // Checks
  // ****************************************
  logic [4:0] edge_gap_q;
  logic       abz_edge;
  logic       enc_a_p_q;
  logic       enc_b_p_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enc_a_p_q <= 1'b0;
      enc_b_p_q <= 1'b0;
    end else begin
      enc_a_p_q <= enc_a_q;
      enc_b_p_q <= enc_b_q;
    end
  end

  assign abz_edge = (enc_a_q != enc_a_p_q) || (enc_b_q != enc_b_p_q);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      edge_gap_q <= 5'h1f;
    end else if (abz_edge) begin
      edge_gap_q <= 5'h00;
    end else if (edge_gap_q != 5'h1f) begin
      edge_gap_q <= edge_gap_q + 5'h01;
    end
  end

  sequence s_b_falls;
    $fell(enc_b_q);
  endsequence

  sequence s_cfg_steady;
    $stable(abz_config_low_q) && $stable(abz_config_high_q);
  endsequence

  a_tick_spacing: assert property (@(posedge ref_clk) disable iff (rst)
    tick |=> !tick [*6] ##1 !tick [*6] ##1 tick)
    else $error("Update tick spacing wrong");

  a_edge_gap: assert property (@(posedge ref_clk) disable iff (rst)
    abz_edge && (edge_gap_q != 5'h1f) |-> edge_gap_q >= 5'(UPDATE_LAST))
    else $error("ABZ edges closer than one update");

  a_quad_single: assert property (@(posedge ref_clk) disable iff (rst)
    !($changed(enc_a_q) && $changed(enc_b_q)))
    else $error("A and B changed together");

  a_z_default: assert property (@(posedge ref_clk) disable iff (rst)
    (index_shape_code == 4'h0) and s_cfg_steady and ($past(pos_q) != $past(pos_q, 2))
    and $past(pos_q < edges_per_turn) and $rose(enc_z_q) |-> s_b_falls)
    else $error("Default index did not rise with B falling");

  a_pos_range: assert property (@(posedge ref_clk) disable iff (rst)
    tick && $stable(abz_config_low_q) |=> pos_q < edges_per_turn)
    else $error("Quadrature position out of turn range");

  a_step_fwd: assert property (@(posedge ref_clk) disable iff (rst)
    tick && (pos_q < edges_per_turn - 11'h001) && (step_dist != 11'h000)
    && (step_dist < half_turn) |=> pos_q == $past(pos_q) + 11'h001)
    else $error("Forward step missing");

  a_hyst_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !ang_away |=> $stable(ang_h_q))
    else $error("Angle moved inside hysteresis band");

  a_hold_still: assert property (@(posedge ref_clk) disable iff (rst)
    (step_dist == 11'h000) && (pos_q < edges_per_turn) |=> $stable(pos_q))
    else $error("Position moved with no angle change");

endmodule

// *** abz_host_model.sv ***
// Host side quadrature counter and PWM capture model
`timescale 1ns/1ps
module abz_host_model (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               enc_a,
  input  wire logic               enc_b,
  input  wire logic               enc_z,
  input  wire logic               pwm_out,
  output      logic signed [15:0] qcnt,
  output      logic signed [15:0] z_at,
  output      logic [15:0]        bad,
  output      logic [15:0]        steps,
  output      logic [15:0]        gap_min,
  output      logic [15:0]        z_rise,
  output      logic [15:0]        z_len,
  output      logic               z_bfall,
  output      logic [15:0]        pwm_hi,
  output      logic [15:0]        pwm_lo,
  output      logic [15:0]        pwm_n
);
  logic [2:0]  abz_p;
  logic        pwm_p;
  logic        mv;
  logic [1:0]  dq;
  logic [15:0] gap;
  logic [15:0] zs;
  logic [15:0] pc;
  assign dq = {~enc_a, ~(enc_a ^ enc_b)} - {~abz_p[2], ~(abz_p[2] ^ abz_p[1])};
  assign mv = (dq != 2'h0);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      abz_p   <= 3'h0;
      qcnt    <= '0;
      z_at    <= '0;
      bad     <= '0;
      steps   <= '0;
      gap     <= 16'hffff;
      gap_min <= 16'hffff;
      z_rise  <= '0;
      z_len   <= '0;
      z_bfall <= 1'b0;
      zs      <= '0;
    end else begin
      abz_p <= {enc_a, enc_b, enc_z};
      // Opposite phase in one sample means a skipped quarter step
      if (dq == 2'h2) bad <= bad + 16'h1;
      if (mv) begin
        qcnt  <= qcnt + 16'(signed'(dq));
        steps <= steps + 16'h1;
      end
      if ({enc_a, enc_b, enc_z} != abz_p) begin
        gap <= 16'h1;
        if (gap < gap_min) gap_min <= gap;
      end else if (gap != 16'hffff) gap <= gap + 16'h1;
      if (enc_z && !abz_p[0]) begin
        z_rise  <= z_rise + 16'h1;
        z_at    <= qcnt + 16'(signed'(dq));
        z_bfall <= abz_p[1] && !enc_b;
        zs      <= '0;
      end else if (mv) zs <= zs + 16'h1;
      if (!enc_z && abz_p[0]) z_len <= zs + 16'(mv);
    end
  end
  // Both phases timed: the pulse rate itself is not trusted
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pwm_p  <= 1'b0;
      pc     <= '0;
      pwm_hi <= '0;
      pwm_lo <= '0;
      pwm_n  <= '0;
    end else begin
      pwm_p <= pwm_out;
      if (pwm_out != pwm_p) begin
        pc <= 16'h1;
        if (pwm_p) pwm_hi <= pc;
        else begin
          pwm_lo <= pc;
          pwm_n  <= pwm_n + 16'h1;
        end
      end else pc <= pc + 16'h1;
    end
  end
endmodule

// *** tb_abz_pwm_angle_output.sv ***
// Self-checking testbench for the ABZ and PWM angle output block
`timescale 1ns/1ps
module tb_abz_pwm_angle_output
  import abz_pkg::*;
();
  logic               ref_clk, rst, cfg_wr_en, enc_a, enc_b, enc_z, pwm_out, z_bfall;
  logic [ANG_W-1:0]   angle;
  logic [ADDR_W-1:0]  cfg_addr;
  logic [7:0]         cfg_wdata, cfg_rdata;
  logic signed [15:0] qcnt, z_at;
  logic [15:0]        bad, steps, gap_min, z_rise, z_len, pwm_hi, pwm_lo, pwm_n;
  logic [31:0]        seed;
  logic [7:0]         cc [4];
  logic [3:0]         cs [4];
  logic [11:0]        pa [3];
  int                 n_fail;
  int                 checks_done;

  abz_pwm_angle_output u_abz_pwm_angle_output (.ref_clk, .rst, .angle, .cfg_wr_en,
    .cfg_addr, .cfg_wdata, .cfg_rdata, .enc_a, .enc_b, .enc_z, .pwm_out);
  abz_host_model u_abz_host_model (.ref_clk, .rst, .enc_a, .enc_b, .enc_z, .pwm_out,
    .qcnt, .z_at, .bad, .steps, .gap_min, .z_rise, .z_len, .z_bfall, .pwm_hi, .pwm_lo,
    .pwm_n);

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Helpers and expectations
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] lo_b(logic [7:0] c, logic [3:0] s);
    return {c[1:0], s[1:0], 4'h0};
  endfunction
  function automatic logic [7:0] hi_b(logic [7:0] c, logic [3:0] s);
    return {s[3:2], c[7:2]};
  endfunction
  function automatic logic [15:0] zlen_exp(logic [1:0] w);
    return (w == 2'h0) ? 16'h2 : (w == 2'h1) ? 16'h1 : (w == 2'h2) ? 16'h3 : 16'h4;
  endfunction
  function automatic logic [15:0] pwm_on(int a);
    return 16'((longint'(PWM_PERIOD) * (4096 + 128 * a)) / (130 * 4096));
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    cfg_addr = a;
    cyc(2);
    chk(16'(cfg_rdata), 16'(e), "read data");
  endtask
  task automatic cfg(input logic [7:0] c, input logic [3:0] s);
    cfg_wr_en = 1'b1;
    cfg_addr  = ADDR_CFG_LOW;
    cfg_wdata = lo_b(c, s);
    cyc(1);
    cfg_addr  = ADDR_CFG_HIGH;
    cfg_wdata = hi_b(c, s);
    cyc(1);
    cfg_wr_en = 1'b0;
    rd(ADDR_CFG_LOW, lo_b(c, s));
    rd(ADDR_CFG_HIGH, hi_b(c, s));
    cyc(60);
  endtask
  // Angle step keeps the target within one quarter step per update
  task automatic turn(input logic [7:0] c, input logic [3:0] s, input bit fwd);
    int n;
    int st;
    logic [15:0] q0;
    logic [15:0] z0;
    n  = int'(c) + 1;
    st = 64;
    while (st * n > 1024) st = st / 2;
    q0 = qcnt;
    z0 = z_rise;
    for (int k = 1; k <= 4096 / st; k++) begin
      angle = fwd ? 12'(k * st) : 12'(4096 - k * st);
      cyc(14);
    end
    cyc(80);
    chk(16'(qcnt - q0), fwd ? 16'(4 * n) : 16'(-4 * n), "edge count");
    chk(16'(z_rise - z0), 16'h1, "index count");
    chk(bad, 16'h0, "quadrature order");
    if (fwd && n > 1) begin
      chk(16'(z_at - q0), 16'(3 + s[1:0]), "index place");
      chk(z_len, zlen_exp(s[3:2]), "index width");
    end
    if (fwd && s[1:0] == 2'h0) chk(16'(z_bfall), 16'h1, "index with b fall");
    $display("turn code %0h shape %0h done", c, s);
  endtask
  task automatic pwm_chk(input logic [11:0] a);
    logic [15:0] p0;
    angle = a;
    p0    = pwm_n;
    for (int i = 0; i < 9000 && 16'(pwm_n - p0) < 16'h2; i++) cyc(1);
    chk(16'(pwm_n - p0), 16'h2, "pwm periods");
    chk(pwm_hi, pwm_on(a), "pwm on time");
    chk(16'(pwm_hi + pwm_lo), 16'(PWM_PERIOD), "pwm period");
    $display("pwm angle %0h done", a);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [15:0] e0;
    seed        = 32'h00004ea7;
    n_fail      = 0;
    checks_done = 0;
    rst         = 1'b1;
    angle       = '0;
    cfg_wr_en   = 1'b0;
    cfg_addr    = '0;
    cfg_wdata   = '0;
    cyc(8);
    rst = 1'b0;
    rd(ADDR_CFG_LOW, lo_b(8'hff, 4'h0));
    rd(ADDR_CFG_HIGH, hi_b(8'hff, 4'h0));
    cfg_wr_en = 1'b1;
    cfg_addr  = 5'h06;
    cfg_wdata = 8'h5a;
    cyc(1);
    cfg_wr_en = 1'b0;
    rd(5'h06, 8'h00);
    rd(ADDR_CFG_LOW, lo_b(8'hff, 4'h0));
    $display("register test done");
    cyc(40);
    turn(8'hff, 4'h0, 1'b1);
    turn(8'hff, 4'h0, 1'b0);
    angle = 12'h008;
    cyc(80);
    e0 = steps;
    repeat (20) begin
      angle = 12'h008 - 12'(rnd() % 3);
      cyc(14);
    end
    chk(16'(steps - e0), 16'h0, "dither quiet");
    angle = 12'h00c;
    cyc(60);
    chk(16'(steps - e0), 16'h1, "one step");
    angle = '0;
    cyc(80);
    $display("hysteresis test done");
    cc = '{8'h77, 8'h01, 8'h08 | 8'(rnd()), 8'h00};
    cs = '{4'h5, 4'ha, 4'hf, 4'h0};
    foreach (cc[i]) begin
      cfg(cc[i], cs[i]);
      turn(cc[i], cs[i], 1'b1);
    end
    pa = '{12'h000, 12'hfff, 12'(rnd())};
    foreach (pa[i]) pwm_chk(pa[i]);
    chk(16'(gap_min >= 16'(UPDATE_CYC)), 16'h1, "edge spacing");
    stop_test();
  end

  // Full run is near 75k cycles; this bound only catches a hang
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_fail++;
    stop_test();
  end
endmodule
